/* rtl/bsf_params.svh */
// Offsets, field positions, reset values and timing counts
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH

// Clock and calibration timing
`define BSF_CLK_PERIOD_NS   20
`define BSF_CAL_TIME_NS     100000
`define BSF_CAL_CNT_W       13

// Fault counter
`define BSF_FCNT_W          3
`define BSF_FCNT_MAX        3'h7
`define BSF_FCNT_MIN        3'h0

// Short-circuit multiplier values and strap codes
`define BSF_MULT_W          4
`define BSF_MULT_LOW        4'h3
`define BSF_MULT_OPEN       4'h7
`define BSF_MULT_HIGH       4'hf
`define BSF_STRAP_10K       2'h1
`define BSF_STRAP_OPEN      2'h0
`define BSF_STRAP_20K       2'h2

// Register byte offsets
`define BSF_ADDR_W          4
`define BSF_REG_CTRL        4'h0
`define BSF_REG_STATUS      4'h4

// Control register fields and reset value
`define BSF_CTRL_RUN_BIT    0
`define BSF_CTRL_RESET      32'h0000_0001

// Status register fields
`define BSF_ST_STATE_LSB    0
`define BSF_ST_FCNT_LSB     4
`define BSF_ST_OCF_BIT      8
`define BSF_ST_OTF_BIT      9
`define BSF_ST_HOT_BIT      10
`define BSF_ST_SSDONE_BIT   11
`define BSF_ST_MULT_LSB     12

`endif

/* rtl/bsf_pkg.sv */
// Types shared by the fault and soft-start sequencer
package bsf_pkg;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_CAL      = 3'b001,
    ST_SOFT     = 3'b010,
    ST_RUN      = 3'b011,
    ST_OC_CHG   = 3'b100,
    ST_OC_DIS   = 3'b101,
    ST_OT_DIS   = 3'b110,
    ST_OT_RETRY = 3'b111
  } bsf_state_t;

  // Comparator and supervisor results, synchronous to clk
  typedef struct packed {
    logic enable_ok;      // Enable pin above turn-on level
    logic uvlo_ok;        // Input undervoltage lockout released
    logic vbp_ok;         // Gate-driver supply above off threshold
    logic ls_over_1x;     // Inverted switch node above limit
    logic ls_over_1p5x;   // Inverted switch node above 1.5x limit
    logic ls_blank_done;  // Low-side blanking elapsed
    logic hs_over;        // High-side drop above multiplier x limit
    logic hs_blank_done;  // High-side blanking elapsed
    logic ss_above_0p5;   // Soft-start node above 0.5 V
    logic ss_above_2p5;   // Soft-start node above 2.5 V
    logic ss_below_0p3;   // Soft-start node below 300 mV
    logic ss_full;        // Soft-start node fully charged
    logic tsd_set;        // Junction above shutdown level
    logic tsd_clear;      // Junction below reset level
  } bsf_sense_t;

  // Soft-start node control
  typedef struct packed {
    logic extra_charge;   // Additional start-up charging source
    logic charge;         // Normal charging source
    logic fast_discharge; // Internal discharge switch
    logic weak_sink;      // Small restart sink current
  } bsf_ss_ctrl_t;

endpackage

/* rtl/bsf_sequencer.sv */
// Overcurrent, short-circuit and soft-start fault sequencer
// ==========================================================
`timescale 1ns/10ps
`include "bsf_params.svh"

module bsf_sequencer #(
  parameter int CAL_CYCLES = `BSF_CAL_TIME_NS / `BSF_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`BSF_ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Analog sensing and oscillator
  input  wire bsf_pkg::bsf_sense_t      sense,
  input  wire logic                     cycle_start,
  input  wire logic [1:0]               multiplier_strap,
  // PWM request and gate drives
  input  wire logic                     pwm_high,
  input  wire logic                     pwm_low,
  output logic                          high_side_drive,
  output logic                          low_side_drive,
  // Soft-start and fault outputs
  output bsf_pkg::bsf_ss_ctrl_t         ss_ctrl,
  output logic [`BSF_MULT_W-1:0]        short_circuit_multiplier,
  output logic                          overcurrent_fault_flag,
  output logic                          overtemp_fault
);

  // ========================================================
  // Declarations
  localparam logic [`BSF_CAL_CNT_W-1:0] CAL_LAST =
    `BSF_CAL_CNT_W'(CAL_CYCLES - 1);

  bsf_pkg::bsf_state_t          state_r;
  bsf_pkg::bsf_state_t          state_nxt;
  logic [31:0]                  ctrl_r;
  logic [`BSF_CAL_CNT_W-1:0]    cal_cnt_r;
  logic [`BSF_FCNT_W-1:0]       fcnt_r;
  logic                         ls_seen_r;
  logic                         ls_over_r;
  logic                         hot_r;
  logic                         ss_done_r;
  logic                         power_ok;
  logic                         ls_over_now;
  logic                         scp_now;
  logic                         oc_trip;
  logic                         switch_en;
  logic                         bus_req;
  logic [31:0]                  status_w;

  // ========================================================
  // Power-up qualification
  assign power_ok = sense.enable_ok & sense.uvlo_ok & sense.vbp_ok &
                    ctrl_r[`BSF_CTRL_RUN_BIT];

  // ========================================================
  // Overcurrent comparator selection and short-circuit detect
  assign ls_over_now = sense.ss_above_2p5 ? sense.ls_over_1x
                                          : sense.ls_over_1p5x;
  assign scp_now = high_side_drive & sense.hs_blank_done &
                   sense.hs_over;
  assign oc_trip = (fcnt_r == `BSF_FCNT_MAX) | scp_now;

  // ========================================================
  // Low-side sample held until the next cycle start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ls_seen_r <= 1'b0;
      ls_over_r <= 1'b0;
    end else if (cycle_start) begin
      ls_seen_r <= 1'b0;
      ls_over_r <= 1'b0;
    end else if (low_side_drive && sense.ls_blank_done) begin
      ls_seen_r <= 1'b1;
      ls_over_r <= ls_over_r | ls_over_now;
    end
  end

  // ========================================================
  // Fault counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fcnt_r <= `BSF_FCNT_MIN;
    end else if (state_r == bsf_pkg::ST_OFF ||
                 state_r == bsf_pkg::ST_CAL) begin
      fcnt_r <= `BSF_FCNT_MIN;
    end else if (scp_now) begin
      fcnt_r <= `BSF_FCNT_MAX;
    end else if (state_r == bsf_pkg::ST_OC_DIS &&
                 sense.ss_below_0p3) begin
      fcnt_r <= `BSF_FCNT_MIN;
    end else if (cycle_start && ls_seen_r &&
                 !overcurrent_fault_flag) begin
      if (ls_over_r) begin
        if (fcnt_r != `BSF_FCNT_MAX) begin
          fcnt_r <= fcnt_r + 3'h1;
        end
      end else if (fcnt_r != `BSF_FCNT_MIN) begin
        fcnt_r <= fcnt_r - 3'h1;
      end
    end
  end

  // ========================================================
  // Calibration timer and multiplier strap
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cal_cnt_r <= '0;
    end else if (state_r == bsf_pkg::ST_CAL) begin
      cal_cnt_r <= cal_cnt_r + `BSF_CAL_CNT_W'(1);
    end else begin
      cal_cnt_r <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      short_circuit_multiplier <= `BSF_MULT_OPEN;
    end else if (state_r == bsf_pkg::ST_CAL) begin
      unique case (multiplier_strap)
        `BSF_STRAP_10K:  short_circuit_multiplier <= `BSF_MULT_LOW;
        `BSF_STRAP_20K:  short_circuit_multiplier <= `BSF_MULT_HIGH;
        default:         short_circuit_multiplier <= `BSF_MULT_OPEN;
      endcase
    end
  end

  // ========================================================
  // Thermal hysteresis and soft-start completion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hot_r <= 1'b0;
    end else if (sense.tsd_set) begin
      hot_r <= 1'b1;
    end else if (sense.tsd_clear) begin
      hot_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ss_done_r <= 1'b0;
    end else if (state_r == bsf_pkg::ST_OFF ||
                 state_r == bsf_pkg::ST_CAL ||
                 state_r == bsf_pkg::ST_OC_DIS) begin
      ss_done_r <= 1'b0;
    end else if (sense.ss_full) begin
      ss_done_r <= 1'b1;
    end
  end

  // ========================================================
  // Sequencer state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bsf_pkg::ST_OFF: begin
        if (power_ok) begin
          state_nxt = bsf_pkg::ST_CAL;
        end
      end
      bsf_pkg::ST_CAL: begin
        if (cal_cnt_r == CAL_LAST) begin
          state_nxt = bsf_pkg::ST_SOFT;
        end
      end
      bsf_pkg::ST_SOFT, bsf_pkg::ST_RUN: begin
        if (oc_trip) begin
          state_nxt = sense.ss_above_2p5 ? bsf_pkg::ST_OC_DIS
                                         : bsf_pkg::ST_OC_CHG;
        end else if (hot_r && (ss_done_r || sense.ss_full)) begin
          state_nxt = bsf_pkg::ST_OT_DIS;
        end else if (state_r == bsf_pkg::ST_SOFT &&
                     sense.ss_full) begin
          state_nxt = bsf_pkg::ST_RUN;
        end
      end
      bsf_pkg::ST_OC_CHG: begin
        if (sense.ss_above_2p5) begin
          state_nxt = bsf_pkg::ST_OC_DIS;
        end
      end
      bsf_pkg::ST_OC_DIS: begin
        if (sense.ss_below_0p3) begin
          state_nxt = bsf_pkg::ST_SOFT;
        end
      end
      bsf_pkg::ST_OT_DIS: begin
        if (sense.ss_below_0p3) begin
          state_nxt = bsf_pkg::ST_OT_RETRY;
        end
      end
      bsf_pkg::ST_OT_RETRY: begin
        if (oc_trip) begin
          state_nxt = sense.ss_above_2p5 ? bsf_pkg::ST_OC_DIS
                                         : bsf_pkg::ST_OC_CHG;
        end else if (sense.ss_full) begin
          state_nxt = hot_r ? bsf_pkg::ST_OT_DIS
                            : bsf_pkg::ST_RUN;
        end
      end
    endcase
    if (!power_ok) begin
      state_nxt = bsf_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= bsf_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ========================================================
  // Fault flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overcurrent_fault_flag <= 1'b0;
    end else if (state_r == bsf_pkg::ST_OFF) begin
      overcurrent_fault_flag <= 1'b0;
    end else if (oc_trip && (state_r == bsf_pkg::ST_SOFT ||
                             state_r == bsf_pkg::ST_RUN ||
                             state_r == bsf_pkg::ST_OT_RETRY)) begin
      overcurrent_fault_flag <= 1'b1;
    end else if (state_r == bsf_pkg::ST_OC_DIS &&
                 sense.ss_below_0p3) begin
      overcurrent_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      overtemp_fault <= 1'b0;
    end else if (state_nxt == bsf_pkg::ST_OT_DIS) begin
      overtemp_fault <= 1'b1;
    end else begin
      overtemp_fault <= 1'b0;
    end
  end

  // ========================================================
  // Soft-start node control
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ss_ctrl <= '0;
    end else begin
      ss_ctrl.fast_discharge <= !sense.uvlo_ok || !sense.vbp_ok ||
                                state_nxt == bsf_pkg::ST_CAL;
      ss_ctrl.weak_sink <= state_nxt == bsf_pkg::ST_OC_DIS ||
                           state_nxt == bsf_pkg::ST_OT_DIS;
      ss_ctrl.charge <= state_nxt == bsf_pkg::ST_SOFT ||
                        state_nxt == bsf_pkg::ST_RUN ||
                        state_nxt == bsf_pkg::ST_OC_CHG ||
                        state_nxt == bsf_pkg::ST_OT_RETRY;
      ss_ctrl.extra_charge <= state_nxt == bsf_pkg::ST_SOFT &&
                              !ss_done_r &&
                              !sense.ss_above_0p5;
    end
  end

  // ========================================================
  // Gate drives
  // Next state, so drives drop with the fault flags
  assign switch_en = !oc_trip &&
                     (state_nxt == bsf_pkg::ST_SOFT ||
                      state_nxt == bsf_pkg::ST_RUN ||
                      state_nxt == bsf_pkg::ST_OT_RETRY);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_side_drive <= 1'b0;
      low_side_drive  <= 1'b0;
    end else begin
      high_side_drive <= switch_en && pwm_high;
      low_side_drive  <= switch_en && pwm_low && !pwm_high;
    end
  end

  // ========================================================
  // Wishbone register access
  assign bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;

  always_comb begin
    status_w = '0;
    status_w[`BSF_ST_STATE_LSB +: 3] = state_r;
    status_w[`BSF_ST_FCNT_LSB +: `BSF_FCNT_W] = fcnt_r;
    status_w[`BSF_ST_OCF_BIT] = overcurrent_fault_flag;
    status_w[`BSF_ST_OTF_BIT] = overtemp_fault;
    status_w[`BSF_ST_HOT_BIT] = hot_r;
    status_w[`BSF_ST_SSDONE_BIT] = ss_done_r;
    status_w[`BSF_ST_MULT_LSB +: `BSF_MULT_W] = short_circuit_multiplier;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= `BSF_CTRL_RESET;
    end else if (bus_req && wb_we_i &&
                 wb_adr_i == `BSF_REG_CTRL && wb_sel_i[0]) begin
      ctrl_r[`BSF_CTRL_RUN_BIT] <= wb_dat_i[`BSF_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `BSF_REG_CTRL:   wb_dat_o <= ctrl_r;
        `BSF_REG_STATUS: wb_dat_o <= status_w;
        default:         wb_dat_o <= '0;
      endcase
    end
  end

endmodule // bsf_sequencer

/* verification/bsf_sequencer_sva.sv */
// Port-level checks for the fault and soft-start sequencer
`timescale 1ns/10ps
`include "bsf_params.svh"

module bsf_sequencer_sva (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // Bus handshake
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  // Sensing and outputs
  input wire bsf_pkg::bsf_sense_t    sense,
  input wire logic                   high_side_drive,
  input wire logic                   low_side_drive,
  input wire bsf_pkg::bsf_ss_ctrl_t  ss_ctrl,
  input wire logic [`BSF_MULT_W-1:0] short_circuit_multiplier,
  input wire logic                   overcurrent_fault_flag,
  input wire logic                   overtemp_fault
);
  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_scp_flag:
    assert property (high_side_drive && sense.hs_blank_done && sense.hs_over
      |=> overcurrent_fault_flag) else $error("short left flag low");
  chk_scp_cut:
    assert property (high_side_drive && sense.hs_blank_done && sense.hs_over
      |=> !high_side_drive) else $error("short kept high drive on");
  chk_flag_drv_off:
    assert property (overcurrent_fault_flag
      |-> !high_side_drive && !low_side_drive) else $error("drive in fault");
  chk_ot_drv_low:
    assert property (overtemp_fault |-> !(high_side_drive || low_side_drive))
      else $error("drive during overtemperature");
  chk_mult_legal:
    assert property (short_circuit_multiplier inside
      {`BSF_MULT_LOW, `BSF_MULT_OPEN, `BSF_MULT_HIGH})
      else $error("bad multiplier");
  chk_uvlo_fast_dis:
    assert property ($past(rstn) && !$past(sense.uvlo_ok)
      |-> ss_ctrl.fast_discharge) else $error("no discharge in lockout");
  chk_vbp_fast_dis:
    assert property ($past(rstn) && !$past(sense.vbp_ok)
      |-> ss_ctrl.fast_discharge) else $error("no discharge on low supply");
  chk_extra_below:
    assert property (ss_ctrl.extra_charge |-> !$past(sense.ss_above_0p5))
      else $error("extra charge above half volt");
  chk_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule // bsf_sequencer_sva

/* verification/bsf_power_stage.sv */
// Behavioural power stage and soft-start capacitor
`timescale 1ns/10ps

module bsf_power_stage (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Gate drives and soft-start control
  input  wire logic                  high_side_drive,
  input  wire logic                  low_side_drive,
  input  wire bsf_pkg::bsf_ss_ctrl_t ss_ctrl,
  // Load: 0 normal, 1 over limit, 2 over 1.5x, 3 short
  input  wire logic [1:0]            load,
  // Comparator results
  output logic                       ls_over_1x,
  output logic                       ls_over_1p5x,
  output logic                       ls_blank_done,
  output logic                       hs_over,
  output logic                       hs_blank_done,
  output logic                       ss_above_0p5,
  output logic                       ss_above_2p5,
  output logic                       ss_below_0p3,
  output logic                       ss_full
);
  logic [1:0] hs_on_r;
  logic [1:0] ls_on_r;
  logic [7:0] ss_v_r;
  logic       tick_r;

  // ==========
  // Blanking, two cycles of drive on
  always_ff @(posedge clk) begin
    hs_on_r <= high_side_drive ? {hs_on_r[0], 1'b1} : 2'h0;
    ls_on_r <= low_side_drive ? {ls_on_r[0], 1'b1} : 2'h0;
    tick_r  <= rstn & ~tick_r;
  end
  assign hs_blank_done = hs_on_r[1];
  assign ls_blank_done = ls_on_r[1];
  // Switch node meaningless when its switch is off
  assign ls_over_1x   = low_side_drive ? (load != 2'h0) : tick_r;
  assign ls_over_1p5x = low_side_drive ? load[1] : tick_r;
  assign hs_over      = high_side_drive ? (load == 2'h3) : tick_r;

  // ==========
  // Capacitor, 25 mV a step
  always_ff @(posedge clk) begin
    if (!rstn || ss_ctrl.fast_discharge) begin
      ss_v_r <= 8'h00;
    end else if (ss_ctrl.weak_sink) begin
      ss_v_r <= ss_v_r - {7'h0, tick_r & (ss_v_r != 8'h00)};
    end else if (ss_v_r < 8'h96) begin
      ss_v_r <= ss_v_r + {6'h0, ss_ctrl.extra_charge, 1'b0}
        + {7'h0, ss_ctrl.charge & tick_r};
    end
  end
  assign ss_above_0p5 = ss_v_r >= 8'h14;
  assign ss_above_2p5 = ss_v_r >= 8'h64;
  assign ss_below_0p3 = ss_v_r < 8'h0c;
  assign ss_full      = ss_v_r >= 8'h8c;
endmodule // bsf_power_stage

/* verification/bsf_sequencer_tb.sv */
// Self-checking bench for the fault and soft-start sequencer
`timescale 1ns/10ps
`include "bsf_params.svh"

bind bsf_sequencer bsf_sequencer_sva i_bsf_sequencer_sva (.clk, .rstn,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sense, .high_side_drive,
  .low_side_drive, .ss_ctrl, .short_circuit_multiplier,
  .overcurrent_fault_flag, .overtemp_fault);

module bsf_sequencer_tb;
  // ==========
  // Signals
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hf;
  logic [31:0] dat = 32'h0, wb_dat_o, lf = 32'h52a4;
  logic wb_ack_o, uvlo = 1'b0, tsd_set = 1'b0, tsd_clr = 1'b0;
  logic gate_driver_supply = 1'b1, en = 1'b1;
  logic cycle_start = 1'b0, pwm_high = 1'b0, pwm_low = 1'b0, flag_q;
  logic [1:0] strap = 2'h0, load = 2'h0;
  logic [2:0] ph = 3'h0, duty = 3'h3;
  logic hsd, lsd, ofl, otf, ls1, ls15, lsb, hso, hsb, s05, s25, s03, sfull;
  logic [3:0] mult;
  bsf_pkg::bsf_ss_ctrl_t ssc;
  bsf_pkg::bsf_sense_t sense;
  logic [1:0] codes[3] = '{`BSF_STRAP_10K, `BSF_STRAP_OPEN, `BSF_STRAP_20K};
  logic [3:0] mults[3] = '{4'h3, 4'h7, 4'hf};
  logic [63:0] notes[$];
  int bad_count = 0, compares = 0, cyc_n = 0, cs_seen = 0, cs_base = 0;

  assign sense = {en, uvlo, gate_driver_supply, ls1, ls15, lsb, hso, hsb, s05, s25, s03,
    sfull, tsd_set, tsd_clr};

  bsf_sequencer #(.CAL_CYCLES(8)) i_bsf_sequencer (.clk, .rstn,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .sense,
    .cycle_start, .multiplier_strap(strap), .pwm_high, .pwm_low,
    .high_side_drive(hsd), .low_side_drive(lsd), .ss_ctrl(ssc),
    .short_circuit_multiplier(mult), .overcurrent_fault_flag(ofl),
    .overtemp_fault(otf));
  bsf_power_stage i_stage (.clk, .rstn, .high_side_drive(hsd),
    .low_side_drive(lsd), .ss_ctrl(ssc), .load, .ls_over_1x(ls1),
    .ls_over_1p5x(ls15), .ls_blank_done(lsb), .hs_over(hso),
    .hs_blank_done(hsb), .ss_above_0p5(s05), .ss_above_2p5(s25),
    .ss_below_0p3(s03), .ss_full(sfull));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pick(input int k);
    return k == 0 ? ofl : (k == 1 ? otf : sfull);
  endfunction

  // ==========
  // Clock, modulator, oscillator, timeout
  always #10 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    cycle_start <= (ph == 3'h7);
    pwm_high <= (ph < duty);
    pwm_low <= (ph > duty);
    if (ph == 3'h7) begin
      lf = lfsr(lf);
      duty <= 3'h3 + {2'h0, lf[0]};
    end
    if (cycle_start === 1'b1) cs_seen <= cs_seen + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========
  // Result monitor
  task automatic take_note(input string what, input logic [31:0] seen);
    logic [63:0] n;
    n = (notes.size() != 0) ? notes.pop_front() : {32'hffffffff, 32'hx};
    compares++;
    if ((seen & n[63:32]) !== n[31:0]) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, n[31:0],
        seen & n[63:32]);
    end
  endtask
  always @(posedge clk) begin
    flag_q <= ofl;
    if (wb_ack_o === 1'b1 && !we) take_note("wb_dat_o", wb_dat_o);
    if (ofl === 1'b1 && flag_q !== 1'b1)
      take_note("cycles_to_flag", 32'(cs_seen - cs_base));
  end

  // ==========
  // Drivers
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, v);
    notes.push_back({m, v});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic st(input bsf_pkg::bsf_state_t s, input logic [2:0] c,
    input logic oc, input logic ot);
    rd(`BSF_REG_STATUS, 32'h0000_037f, {22'h0, ot, oc, 1'b0, c, 1'b0, s});
  endtask
  task automatic wait_hi(input int k, input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(k) !== lvl && n < 3000);
    if (n == 3000) bad_count++;
  endtask
  task automatic wait_cs(input int k);
    repeat (k) do @(posedge clk); while (cycle_start !== 1'b1);
  endtask
  task automatic tsd(input logic s);
    @(posedge clk);
    tsd_set <= s;
    tsd_clr <= !s;
    @(posedge clk);
    tsd_set <= 1'b0;
    tsd_clr <= 1'b0;
  endtask
  task automatic arm(input logic [1:0] l, input logic [31:0] n);
    wait_cs(1);
    cs_base = cs_seen + 1;
    notes.push_back({32'hffffffff, n});
    load <= l;
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    st(bsf_pkg::ST_OFF, 3'h0, 1'b0, 1'b0);
    rd(`BSF_REG_CTRL, 32'hffffffff, `BSF_CTRL_RESET);
    rd(4'h8, 32'hffffffff, 32'h0);
    uvlo <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `BSF_REG_CTRL, 32'h0);
      rd(`BSF_REG_CTRL, 32'h1, 32'h0);
      strap <= codes[i];
      wb(1'b1, `BSF_REG_CTRL, 32'h1);
      wait_hi(2, 1'b0);
      if (i == 0) begin
        wait_cs(3);
        tsd(1'b1);
        tsd(1'b0);
        st(bsf_pkg::ST_SOFT, 3'h0, 1'b0, 1'b0);
      end
      wait_hi(2, 1'b1);
      strap <= 2'h3;
      rd(`BSF_REG_STATUS, 32'hf007, {16'h0, mults[i], 12'h003});
    end
    wait_cs(1);
    load <= 2'h1;
    wait_cs(3);
    load <= 2'h0;
    wait_cs(1);
    st(bsf_pkg::ST_RUN, 3'h2, 1'b0, 1'b0);
    wait_cs(4);
    st(bsf_pkg::ST_RUN, 3'h0, 1'b0, 1'b0);
    arm(2'h1, 32'h7);
    wait_hi(0, 1'b1);
    st(bsf_pkg::ST_OC_DIS, 3'h7, 1'b1, 1'b0);
    wait_hi(0, 1'b0);
    wait_cs(4);
    st(bsf_pkg::ST_SOFT, 3'h0, 1'b0, 1'b0);
    arm(2'h2, 32'h7);
    wait_hi(0, 1'b1);
    st(bsf_pkg::ST_OC_CHG, 3'h7, 1'b1, 1'b0);
    load <= 2'h0;
    wait_hi(0, 1'b0);
    wait_hi(2, 1'b1);
    arm(2'h3, 32'h0);
    wait_hi(0, 1'b1);
    st(bsf_pkg::ST_OC_DIS, 3'h7, 1'b1, 1'b0);
    load <= 2'h0;
    wait_hi(0, 1'b0);
    wait_hi(2, 1'b1);
    tsd(1'b1);
    wait_hi(1, 1'b1);
    st(bsf_pkg::ST_OT_DIS, 3'h0, 1'b0, 1'b1);
    wait_hi(1, 1'b0);
    st(bsf_pkg::ST_OT_RETRY, 3'h0, 1'b0, 1'b0);
    wait_hi(1, 1'b1);
    tsd(1'b0);
    wait_hi(1, 1'b0);
    wait_hi(2, 1'b1);
    st(bsf_pkg::ST_RUN, 3'h0, 1'b0, 1'b0);
    gate_driver_supply <= 1'b0;
    wait_hi(2, 1'b0);
    st(bsf_pkg::ST_OFF, 3'h0, 1'b0, 1'b0);
    gate_driver_supply <= 1'b1;
    en <= 1'b0;
    st(bsf_pkg::ST_OFF, 3'h0, 1'b0, 1'b0);
    en <= 1'b1;
    st(bsf_pkg::ST_CAL, 3'h0, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // bsf_sequencer_tb
